// ==== hw/swsc_pkg.sv ====
package swsc_pkg;
    // ---------------------------------------------------------------
    // register map (byte offsets, one 32-bit word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] SWSC_CFG_OFS   = 8'h00; // mode, unit, point
    localparam logic [7:0] SWSC_SCA_OFS   = 8'h04; // input a scaling
    localparam logic [7:0] SWSC_SCB_OFS   = 8'h08; // input b scaling
    localparam logic [7:0] SWSC_STAT_OFS  = 8'h0c; // live state
    localparam logic [7:0] SWSC_DISP_OFS  = 8'h10; // shown time
    localparam logic [7:0] SWSC_TIME_OFS  = 8'h14; // internal time
    // field positions
    localparam int SWSC_CFG_UNIT_POS = 8;
    localparam int SWSC_CFG_DP_POS   = 12;
    localparam int SWSC_SC_EXP_POS   = 16;
    // measuring types that matter here
    localparam logic [4:0] SWSC_TYPE_PASS  = 5'h08;
    localparam logic [4:0] SWSC_TYPE_SHOT0 = 5'h09;
    localparam logic [4:0] SWSC_TYPE_SHOT3 = 5'h0c;
    localparam logic [4:0] SWSC_TYPE_CYCLE = 5'h0d;
    localparam logic [4:0] SWSC_TYPE_SWA   = 5'h0e;
    localparam logic [4:0] SWSC_TYPE_SWB   = 5'h0f;
    // measuring units
    localparam logic [2:0] SWSC_U_HOUR = 3'h0;
    localparam logic [2:0] SWSC_U_MIN  = 3'h1;
    localparam logic [2:0] SWSC_U_SEC  = 3'h2;
    localparam logic [2:0] SWSC_U_HM   = 3'h3;
    localparam logic [2:0] SWSC_U_MS   = 3'h4;
    // scaling limits
    localparam logic [13:0] SWSC_MANT_MIN = 14'h0001;
    localparam logic [13:0] SWSC_MANT_MAX = 14'h270f; // 9999
    localparam logic [3:0]  SWSC_EXP_MAX  = 4'h9;
    // reset values
    localparam logic [31:0] SWSC_CFG_RST  = 32'h0000_020e; // swa, second
    localparam logic [13:0] SWSC_MANT_RST = 14'h0001;
    localparam logic [3:0]  SWSC_EXP_RST  = 4'h0;
    // timing: 50 MHz clock, one second in cycles
    localparam int          SWSC_CLK_NS   = 20;
    localparam longint      SWSC_SEC_NS   = 1000000000;
    localparam logic [39:0] SWSC_SEC_CYC  = 40'(SWSC_SEC_NS / SWSC_CLK_NS);
    localparam logic [39:0] SWSC_MIN_MUL  = 40'h3c;  // 60
    localparam logic [39:0] SWSC_HOUR_MUL = 40'he10; // 3600
    // interpretation of the scaling value
    localparam logic [1:0] SWSC_SI_PLAIN = 2'h0;
    localparam logic [1:0] SWSC_SI_MMPP  = 2'h1; // millimetres per pulse
    localparam logic [1:0] SWSC_SI_DIST  = 2'h2; // sensor spacing

    typedef struct packed {
        logic [4:0] mtype;
        logic [2:0] unit;
        logic [1:0] dp;
    } swsc_cfg_t;

    typedef struct packed {
        logic [13:0] mant;
        logic [3:0]  expo;
    } swsc_scale_t;

    typedef enum logic [1:0] {
        SWSC_IDLE,
        SWSC_RUN,
        SWSC_LAP
    } swsc_state_t;
endpackage

// ==== hw/swsc_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Overview of operation
// ---------------------------------------------------------------
module swsc_top
    import swsc_pkg::*;
#(
    parameter logic [39:0] SEC_CYCLES = SWSC_SEC_CYC // shorten in sim
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sens_a_n_i,  // open collector, low = on
    input  wire logic        sens_b_n_i,
    input  wire logic        rst_in_n_i,  // reset contact, low = on
    output logic      [31:0] disp_o,      // shown time in ticks
    output logic             running_o,
    output logic             lap_o,
    output logic      [2:0]  unit_eff_o,
    output logic      [1:0]  dp_eff_o     // for preset setpoints
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // compound units survive only for timing types, else fall back
    function automatic logic [2:0] eff_unit(input swsc_cfg_t c);
        logic timing;
        timing = (c.mtype == SWSC_TYPE_PASS) ||
                 (c.mtype == SWSC_TYPE_CYCLE) ||
                 (c.mtype == SWSC_TYPE_SWA) ||
                 (c.mtype == SWSC_TYPE_SWB);
        if (c.unit > SWSC_U_MS) begin
            eff_unit = SWSC_U_SEC;            // reserved codes
        end else if (c.unit >= SWSC_U_HM && !timing) begin
            eff_unit = c.unit - 3'h2;
        end else begin
            eff_unit = c.unit;
        end
    endfunction

    // cycles per display step; hm counts minutes, ms seconds
    function automatic logic [39:0] tick_len(input logic [2:0] u,
                                             input logic [1:0] dp);
        logic [39:0] base;
        base = SEC_CYCLES;
        if (u == SWSC_U_HOUR) begin
            base = SEC_CYCLES * SWSC_HOUR_MUL;
        end else if (u == SWSC_U_MIN || u == SWSC_U_HM) begin
            base = SEC_CYCLES * SWSC_MIN_MUL;
        end
        if (u == SWSC_U_HM || u == SWSC_U_MS) begin
            tick_len = base;
        end else begin
            unique case (dp)
                2'h0: tick_len = base;
                2'h1: tick_len = base / 40'ha;
                2'h2: tick_len = base / 40'h64;
                2'h3: tick_len = base / 40'h3e8;
            endcase
        end
        if (tick_len == 40'h0) begin
            tick_len = 40'h1;
        end
    endfunction

    // scaling write: refuse an illegal mantissa, clamp the exponent
    function automatic swsc_scale_t sc_write(input swsc_scale_t old,
                                             input logic [31:0] d);
        sc_write = old;
        if (d[13:0] >= SWSC_MANT_MIN && d[13:0] <= SWSC_MANT_MAX) begin
            sc_write.mant = d[13:0];
        end
        sc_write.expo = (d[SWSC_SC_EXP_POS+:4] > SWSC_EXP_MAX) ?
                        SWSC_EXP_MAX : d[SWSC_SC_EXP_POS+:4];
    endfunction

    // ---------------------------------------------------------------
    // input synchronisers and edge detect
    // ---------------------------------------------------------------
    logic [2:0] sync1_reg, sync1_next;  // first stage, read by stage 2
    logic [2:0] sync2_reg, sync2_next;  // clean levels, 1 = on
    logic [2:0] last_reg,  last_next;   // for rising edge
    logic [2:0] edge_w;                 // one-cycle activation

    // pins are active low; invert so that 1 means activated
    always_comb begin
        sync1_next = ~{rst_in_n_i, sens_b_n_i, sens_a_n_i};
        sync2_next = sync1_reg;
        last_next  = sync2_reg;
        edge_w     = sync2_reg & ~last_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            last_reg  <= 3'h0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            last_reg  <= last_next;
        end
    end

    // ---------------------------------------------------------------
    // configuration registers and wishbone slave
    // ---------------------------------------------------------------
    swsc_cfg_t   cfg_reg,  cfg_next;
    swsc_scale_t sca_reg,  sca_next;    // input a, own scaling
    swsc_scale_t scb_reg,  scb_next;    // input b, own scaling
    logic [31:0] rd_reg,   rd_next;
    logic        ack_reg,  ack_next;
    logic        wr_w;                  // write takes effect
    logic [2:0]  unit_w;
    logic [1:0]  dp_w;
    logic [1:0]  sint_w;                // scale interpretation

    logic [31:0]  disp_reg, disp_next;
    logic [31:0]  cnt_reg,  cnt_next;
    swsc_state_t  st_reg,   st_next;

    always_comb begin
        unit_w = eff_unit(cfg_reg);
        // compound unit: no point position at all
        dp_w   = (unit_w >= SWSC_U_HM) ? 2'h0 : cfg_reg.dp;
        if (cfg_reg.mtype == SWSC_TYPE_PASS) begin
            sint_w = SWSC_SI_MMPP;
        end else if (cfg_reg.mtype >= SWSC_TYPE_SHOT0 &&
                     cfg_reg.mtype <= SWSC_TYPE_SHOT3) begin
            sint_w = SWSC_SI_DIST;
        end else begin
            sint_w = SWSC_SI_PLAIN;
        end
    end

    // single-cycle ack; byte lane 0 must be selected for a write
    always_comb begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        // commit on the edge that shows ack to the master, not before
        wr_w     = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i &&
                   wb_sel_i[0];
        cfg_next = cfg_reg;
        sca_next = sca_reg;
        scb_next = scb_reg;
        rd_next  = 32'h0;  // unmapped reads as zero, still acked
        if (wr_w) begin
            unique case (wb_adr_i)
                SWSC_CFG_OFS: begin
                    cfg_next.mtype = wb_dat_i[4:0];
                    cfg_next.unit  = wb_dat_i[SWSC_CFG_UNIT_POS+:3];
                    cfg_next.dp    = wb_dat_i[SWSC_CFG_DP_POS+:2];
                end
                SWSC_SCA_OFS: sca_next = sc_write(sca_reg, wb_dat_i);
                SWSC_SCB_OFS: scb_next = sc_write(scb_reg, wb_dat_i);
                default: ;
            endcase
        end
        unique case (wb_adr_i)
            SWSC_CFG_OFS:  rd_next = {18'h0, cfg_reg.dp, 1'b0,
                                      cfg_reg.unit, 3'h0, cfg_reg.mtype};
            SWSC_SCA_OFS:  rd_next = {12'h0, sca_reg.expo, 2'h0,
                                      sca_reg.mant};
            SWSC_SCB_OFS:  rd_next = {12'h0, scb_reg.expo, 2'h0,
                                      scb_reg.mant};
            SWSC_STAT_OFS: rd_next = {23'h0, sint_w, dp_w, unit_w,
                                      (st_reg == SWSC_LAP),
                                      (st_reg != SWSC_IDLE)};
            SWSC_DISP_OFS: rd_next = disp_reg;
            SWSC_TIME_OFS: rd_next = cnt_reg;
            default:       rd_next = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg  <= '{mtype: SWSC_CFG_RST[4:0],
                          unit:  SWSC_CFG_RST[SWSC_CFG_UNIT_POS+:3],
                          dp:    SWSC_CFG_RST[SWSC_CFG_DP_POS+:2]};
            sca_reg  <= '{mant: SWSC_MANT_RST, expo: SWSC_EXP_RST};
            scb_reg  <= '{mant: SWSC_MANT_RST, expo: SWSC_EXP_RST};
            rd_reg   <= 32'h0;
            ack_reg  <= 1'b0;
        end else begin
            cfg_reg  <= cfg_next;
            sca_reg  <= sca_next;
            scb_reg  <= scb_next;
            rd_reg   <= rd_next;
            ack_reg  <= ack_next;
        end
    end

    // ---------------------------------------------------------------
    // timing engine
    // ---------------------------------------------------------------
    logic [39:0] pre_reg, pre_next;  // prescaler to one display step
    logic        tick_w;
    logic        count_w;            // prescaler advances this cycle
    logic        is_swa, is_swb, is_cyc;
    logic        cfg_chg_w;          // mode change aborts timing

    always_comb begin
        is_swa    = (cfg_reg.mtype == SWSC_TYPE_SWA);
        is_swb    = (cfg_reg.mtype == SWSC_TYPE_SWB);
        is_cyc    = (cfg_reg.mtype == SWSC_TYPE_CYCLE);
        cfg_chg_w = (cfg_next != cfg_reg);
        // cycle timer holds still while b is on
        count_w   = (st_reg != SWSC_IDLE) &&
                    !(is_cyc && sync2_reg[1]);
        tick_w    = count_w &&
                    (pre_reg >= tick_len(unit_w, dp_w) - 40'h1);
        pre_next  = count_w ? (tick_w ? 40'h0 : pre_reg + 40'h1)
                            : pre_reg;
        cnt_next  = (tick_w && cnt_reg != 32'hffff_ffff) ?
                    cnt_reg + 32'h1 : cnt_reg;          // saturates
        st_next   = st_reg;
        disp_next = (st_reg == SWSC_RUN && !is_cyc) ? cnt_next : disp_reg;
        if (edge_w[2] || cfg_chg_w ||
            !(is_swa || is_swb || is_cyc)) begin
            // reset contact clears both values and stops
            st_next   = SWSC_IDLE;
            cnt_next  = 32'h0;
            disp_next = 32'h0;
            pre_next  = 40'h0;
        end else if (is_cyc) begin
            if (edge_w[0]) begin
                disp_next = cnt_reg;
                cnt_next  = 32'h0;
                pre_next  = 40'h0;
                st_next   = SWSC_RUN;
            end
        end else begin
            unique case (st_reg)
                SWSC_IDLE: if (edge_w[0]) begin
                    st_next   = SWSC_RUN;
                    cnt_next  = 32'h0;
                    disp_next = 32'h0;
                    pre_next  = 40'h0;
                end
                SWSC_RUN: if (edge_w[0] && is_swa) begin
                    st_next   = SWSC_IDLE;
                    disp_next = cnt_next;   // include a tick landing now
                end else if (edge_w[1] && is_swb) begin
                    st_next   = SWSC_IDLE;
                    disp_next = cnt_next;
                end else if (edge_w[1]) begin
                    st_next   = SWSC_LAP;
                    disp_next = cnt_reg;
                end
                SWSC_LAP: if (edge_w[0]) begin
                    st_next   = SWSC_IDLE;
                    disp_next = cnt_next;   // shown equals frozen counter
                end else if (edge_w[1]) begin
                    st_next   = SWSC_RUN;
                    disp_next = cnt_next;
                end
            endcase
        end
    end

    // power-up reset zeroes state, counter, display and prescaler; nothing survives an outage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg   <= SWSC_IDLE;
            cnt_reg  <= 32'h0;
            disp_reg <= 32'h0;
            pre_reg  <= 40'h0;
        end else begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            disp_reg <= disp_next;
            pre_reg  <= pre_next;
        end
    end

    // ---------------------------------------------------------------
    // output registers
    // ---------------------------------------------------------------
    logic [2:0]  uo_reg;
    logic [1:0]  dpo_reg;
    logic        run_reg;  // tracks st_reg, but straight from a flop
    logic        lap_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uo_reg  <= SWSC_U_SEC;
            dpo_reg <= 2'h0;
            run_reg <= 1'b0;
            lap_reg <= 1'b0;
        end else begin
            uo_reg  <= unit_w;
            dpo_reg <= dp_w;
            run_reg <= (st_next != SWSC_IDLE);
            lap_reg <= (st_next == SWSC_LAP);
        end
    end

    always_comb begin
        wb_dat_o   = rd_reg;
        wb_ack_o   = ack_reg;
        disp_o     = disp_reg;
        running_o  = run_reg;
        lap_o      = lap_reg;
        unit_eff_o = uo_reg;
        dp_eff_o   = dpo_reg;
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_lap_taken;
        is_swa && st_reg == SWSC_RUN && edge_w[1] && !edge_w[0] &&
        !edge_w[2] && !cfg_chg_w;
    endsequence

    start_a_runs_a: assert property (
        is_swa && !cfg_chg_w && st_reg == SWSC_IDLE && edge_w[0] &&
        !edge_w[2] |=> st_reg == SWSC_RUN && cnt_reg == 32'h0)
        else $error("watch a did not start");
    lap_freeze_a: assert property (
        s_lap_taken |=> lap_o && disp_o == $past(cnt_reg))
        else $error("lap did not freeze display");
    lap_stop_a: assert property (
        is_swa && st_reg == SWSC_LAP && edge_w[0] && !edge_w[2] &&
        !cfg_chg_w |=> st_reg == SWSC_IDLE && disp_o == cnt_reg)
        else $error("a after lap did not stop");
    reset_clears_a: assert property (
        edge_w[2] |=> disp_o == 32'h0 && !running_o && cnt_reg == 32'h0)
        else $error("reset contact did not clear");
    stop_b_a: assert property (
        is_swb && st_reg == SWSC_RUN && edge_w[1] && !edge_w[0] &&
        !edge_w[2] && !cfg_chg_w |=> !running_o)
        else $error("watch b did not stop");
    unit_fold_a: assert property (
        cfg_reg.unit == SWSC_U_HM && cfg_reg.mtype < SWSC_TYPE_PASS
        |-> unit_w == SWSC_U_MIN)
        else $error("compound unit kept for rate type");
    dp_ignore_a: assert property (
        unit_w >= SWSC_U_HM |=> dp_eff_o == 2'h0)
        else $error("point kept for compound unit");
    mant_legal_a: assert property (
        sca_reg.mant >= SWSC_MANT_MIN && sca_reg.mant <= SWSC_MANT_MAX &&
        scb_reg.mant != 14'h0)
        else $error("illegal scaling mantissa stored");
    cyc_hold_a: assert property (
        is_cyc && sync2_reg[1] && !edge_w[0] && !edge_w[2] &&
        !cfg_chg_w |=> cnt_reg == $past(cnt_reg))
        else $error("cycle timer ran while suspended");
    edge_once_a: assert property (
        edge_w[0] |=> !edge_w[0])
        else $error("activation seen twice");
endmodule
`default_nettype wire

// ==== verif/swsc_contact_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// contact model: two open-collector sensors and a reset contact
// ---------------------------------------------------------------
module swsc_contact_model #(
    parameter int HOLD = 4 // closed cycles per press, at least 3
) (
    input  wire logic       clk_i,
    input  wire logic [2:0] press_i,    // 0 sensor a, 1 sensor b, 2 reset
    output logic            sens_a_n_o, // low while closed
    output logic            sens_b_n_o,
    output logic            rst_in_n_o
);
    int hold_reg [3] = '{0, 0, 0}; // closed cycles left; all open at start

    // a press closes the contact for HOLD cycles, long enough for the
    // two sync stages and the edge register to see it only once
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 3; i++) begin
            if (press_i[i]) begin
                hold_reg[i] <= HOLD;
            end else if (hold_reg[i] > 0) begin
                hold_reg[i] <= hold_reg[i] - 1;
            end
        end
    end

    // open collector with pull-up: a released line reads high
    always_comb begin
        sens_a_n_o = !(hold_reg[0] > 0);
        sens_b_n_o = !(hold_reg[1] > 0);
        rst_in_n_o = !(hold_reg[2] > 0);
    end
endmodule
`default_nettype wire

// ==== verif/swsc_top_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// bench for the stopwatch and scaling block
// ---------------------------------------------------------------
module swsc_top_bench;
    import swsc_pkg::*;
    typedef struct packed {
        logic [4:0] mtype;
        logic [2:0] unit;
        logic [1:0] dp;
        logic [2:0] u_exp;  // expected effective unit
        logic [1:0] dp_exp; // expected effective point
        logic [1:0] si_exp; // expected scale meaning
    } swsc_row_t;
    logic        clk, rst, cyc, stb, we, ack;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, disp, v, t;
    logic [2:0]  press, unit_eff;
    logic [1:0]  dp_eff;
    logic        sa_n, sb_n, rc_n, running, lap;
    int          failures = 0;
    int          num_checks = 0;
    // one row per configuration: cfg fields beside their effect
    swsc_row_t rows [7] = '{
        '{SWSC_TYPE_SWA,   SWSC_U_HM,  2'h2, SWSC_U_HM,  2'h0, 2'h0},
        '{SWSC_TYPE_SWA,   SWSC_U_SEC, 2'h3, SWSC_U_SEC, 2'h3, 2'h0},
        '{5'h03,           SWSC_U_HM,  2'h0, SWSC_U_MIN, 2'h0, 2'h0},
        '{SWSC_TYPE_SHOT0, SWSC_U_MS,  2'h0, SWSC_U_SEC, 2'h0, 2'h2},
        '{SWSC_TYPE_PASS,  SWSC_U_MS,  2'h1, SWSC_U_MS,  2'h0, 2'h1},
        '{SWSC_TYPE_SHOT3, SWSC_U_HM,  2'h0, SWSC_U_MIN, 2'h0, 2'h2},
        '{SWSC_TYPE_CYCLE, SWSC_U_MS,  2'h2, SWSC_U_MS,  2'h0, 2'h0}};

    // 40 cycles a second: a tick is four cycles at one decimal, one cycle at two or three
    swsc_top #(.SEC_CYCLES(40'd40)) i_dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .sens_a_n_i(sa_n),
        .sens_b_n_i(sb_n), .rst_in_n_i(rc_n), .disp_o(disp),
        .running_o(running), .lap_o(lap), .unit_eff_o(unit_eff),
        .dp_eff_o(dp_eff));
    swsc_contact_model #(.HOLD(4)) i_contacts (
        .clk_i(clk), .press_i(press), .sens_a_n_o(sa_n),
        .sens_b_n_o(sb_n), .rst_in_n_o(rc_n));

    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end

    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check_val(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_flag(string nm, logic e, logic g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    // classic single wishbone cycle; waits for ack, never a fixed count
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    // close one contact, then give sync and edge logic time to settle
    task automatic hit(input int i);
        @(posedge clk);
        press <= 3'(1 << i);
        @(posedge clk);
        press <= 3'h0;
        repeat (14) @(posedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run;
    end

    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        wdat = 32'h0; press = 3'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_val("disp after reset", 32'h0, disp);
        check_val("unit after reset", 32'h2, 32'(unit_eff));
        wb(0, SWSC_CFG_OFS, 0, v);
        check_val("cfg reset", SWSC_CFG_RST, v);
        foreach (rows[i]) begin
            wb(1, SWSC_CFG_OFS, {18'h0, rows[i].dp, 1'b0, rows[i].unit,
               3'h0, rows[i].mtype}, v);
            wb(0, SWSC_STAT_OFS, 0, v);
            check_val("eff unit", 32'(rows[i].u_exp), 32'(unit_eff));
            check_val("eff point", 32'(rows[i].dp_exp), 32'(dp_eff));
            check_val("scale use", 32'(rows[i].si_exp), 32'(v[8:7]));
        end
        // scaling: zero and over-range mantissa refused, exponent clamps
        wb(1, SWSC_SCA_OFS, 32'h0006_04d2, v);
        wb(1, SWSC_SCB_OFS, 32'h0009_270f, v);
        wb(1, SWSC_SCA_OFS, 32'h0003_0000, v);
        wb(0, SWSC_SCA_OFS, 0, v);
        check_val("scale a zero", 32'h0003_04d2, v);
        wb(1, SWSC_SCB_OFS, 32'h000f_2710, v);
        wb(0, SWSC_SCB_OFS, 0, v);
        check_val("scale b", 32'h0009_270f, v);
        wb(0, 8'h20, 0, v);
        check_val("unmapped", 32'h0, v);
        // stopwatch a, second unit, one decimal
        wb(1, SWSC_CFG_OFS, 32'h0000_120e, v);
        hit(0);
        check_flag("a start", 1'b1, running);
        hit(1);
        check_flag("lap on", 1'b1, lap);
        v = disp;
        repeat (20) @(posedge clk);
        check_val("lap frozen", v, disp);
        wb(0, SWSC_TIME_OFS, 0, t);
        check_flag("time runs", 1'b1, t > v);
        hit(1);
        check_flag("lap off", 1'b0, lap);
        check_flag("live again", 1'b1, disp > v);
        hit(1);
        hit(0);
        check_flag("a after lap", 1'b0, running);
        wb(0, SWSC_TIME_OFS, 0, t);
        check_val("lap stop time", t, disp);
        hit(2);
        check_val("contact zero", 32'h0, disp);
        hit(0);
        hit(0);
        check_flag("a stop", 1'b0, running);
        v = disp;
        repeat (20) @(posedge clk);
        check_val("stop holds", v, disp);
        // stopwatch b
        wb(1, SWSC_CFG_OFS, 32'h0000_320f, v);
        hit(0);
        check_flag("b start", 1'b1, running);
        hit(1);
        check_flag("b stop", 1'b0, running);
        check_flag("b shown", 1'b1, disp > 0);
        hit(2);
        wb(0, SWSC_TIME_OFS, 0, t);
        check_val("b counter", 32'h0, t);
        check_val("b disp", 32'h0, disp);
        // cycle timer: second a shows the cycle and keeps timing
        wb(1, SWSC_CFG_OFS, 32'h0000_320d, v);
        hit(0);
        hit(0);
        check_flag("cycle run", 1'b1, running);
        check_flag("cycle shown", 1'b1, disp > 0);
        v = disp;
        hit(1);
        check_flag("cycle b run", 1'b1, running);
        check_val("cycle b shown", v, disp);
        hit(2);
        check_val("cycle zero", 32'h0, disp);
        // power loss while timing clears everything
        wb(1, SWSC_CFG_OFS, 32'h0000_020e, v);
        hit(0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_val("power zero", 32'h0, disp);
        check_flag("power idle", 1'b0, running);
        complete_run;
    end
endmodule
`default_nettype wire
